// ### inc/eeprom_slave_map.vh
// constants for the two-wire eeprom slave front end
`ifndef EEPROM_SLAVE_MAP_VH
`define EEPROM_SLAVE_MAP_VH
`define TYPE_PATTERN      4'ha
`define DENS_1K           3'h0
`define DENS_2K           3'h1
`define DENS_4K           3'h2
`define DENS_8K           3'h3
`define DENS_16K          3'h4
`define FILTER_NS         200
`define CLK_NS            100
`define FILTER_CYCLES     ((`FILTER_NS + `CLK_NS - 1) / `CLK_NS)
`define FILTER_W          2
`define WRITE_CYCLE_US    10000
`define WRITE_CYCLE_COUNT ((`WRITE_CYCLE_US * 1000) / `CLK_NS)
`define BIT_CNT_W         4
`define BIT_ACK           4'h8
`define BIT_LAST          4'h7
`define BIT_PRE           4'hf
`endif

// ### verilog/line_filter.v
// two-flop synchroniser and glitch filter for one bus line
`timescale 1ns/1ns
`include "eeprom_slave_map.vh"
module line_filter
(
  input  wire clk_sys,
  input  wire rst_n,
  input  wire clk_en,
  input  wire line_in,
  output reg  line_out
);
  reg                  sync_a;
  reg                  sync_b;
  reg [`FILTER_W-1:0]  stable_cnt;

  // first flop feeds only the second; filter works on sync_b
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync_a     <= 1'b1;
      sync_b     <= 1'b1;
      stable_cnt <= {`FILTER_W{1'b0}};
      line_out   <= 1'b1;
    end
    else if (clk_en)
    begin
      sync_a <= line_in;
      sync_b <= sync_a;
      // a new level must hold past the noise time before it counts
      if (sync_b == line_out)
        stable_cnt <= {`FILTER_W{1'b0}};
      else if (stable_cnt == `FILTER_CYCLES - 1)
      begin
        line_out   <= sync_b;
        stable_cnt <= {`FILTER_W{1'b0}};
      end
      else
        stable_cnt <= stable_cnt + 1'b1;
    end
  end
endmodule // line_filter

// ### verilog/busy_timer.v
// self-timed programming cycle counter
`timescale 1ns/1ns
`include "eeprom_slave_map.vh"
module busy_timer
#(
  parameter WRITE_CYCLES = `WRITE_CYCLE_COUNT
)
(
  input  wire clk_sys,
  input  wire rst_n,
  input  wire clk_en,
  input  wire start,
  output reg  busy
);
  reg [16:0] remain;

  // counts down from the write stop; busy blanks the bus interface
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      busy   <= 1'b0;
      remain <= 17'h00000;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        busy   <= 1'b1;
        remain <= WRITE_CYCLES[16:0];
      end
      else if (busy)
      begin
        if (remain == 17'h00001)
          busy <= 1'b0;
        remain <= remain - 17'h00001;
      end
    end
  end
endmodule // busy_timer

// ### verilog/eeprom_serial_slave_interface.v
// two-wire serial eeprom slave front end
// Behaviour
// - bus sharing count depends on density
// - data line only pulled low or released
// - floating select pins read zero, smallest grounded
// - middle density ignores select pin zero
// - second largest matches select pin two only
// - largest density matches no select pins
// - write protect high blocks programming
// - data change with clock high is start/stop
// - start is data fall, clock high
// - stop is data rise, clock high
// - address type bits must be 1010
// - select bits match pins or give high address
// - last address bit: 1 read, 0 write
// - acknowledge only a matching address
// - receiver holds data low on ninth clock
// - selected for write, acknowledge every byte
// - read: eight bits, release, sample acknowledge
// - no acknowledge ends reading until stop
// - no acknowledge during programming cycle
// - protected: ack address bytes, nak first data
`timescale 1ns/1ns
`include "eeprom_slave_map.vh"
module eeprom_serial_slave_interface
#(
  parameter WRITE_CYCLES = `WRITE_CYCLE_COUNT
)
(
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire [2:0] density,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       select_pin_zero,
  input  wire       select_pin_one,
  input  wire       select_pin_two,
  input  wire       write_protect,
  input  wire [7:0] read_data,
  output reg        read_data_req,
  output reg        selected,
  output reg        read_mode,
  output reg  [2:0] high_address,
  output reg  [7:0] rx_byte,
  output reg        rx_addr_valid,
  output reg        rx_data_valid,
  output reg        program_start,
  output reg        busy
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_WRITE = 3'h2;
  localparam ST_READ  = 3'h3;
  localparam ST_WAIT  = 3'h4;

  wire                  scl_f;
  wire                  sda_f;
  wire                  busy_int;
  reg                   scl_d;
  reg                   sda_d;
  reg  [2:0]            state;
  reg  [`BIT_CNT_W-1:0] bit_cnt;
  reg  [7:0]            shift;
  reg  [7:0]            tx_shift;
  reg                   pend_ack;
  reg                   bytes_seen;
  reg                   wrote_data;
  reg  [2:0]            wp_sync;
  reg  [2:0]            pin_a;
  reg  [2:0]            pin_b;

  // which select bits compare to pins, per density
  function [2:0] used_mask;
    input [2:0] dens;
    begin
      case (dens)
        `DENS_4K: used_mask = 3'h6;
        `DENS_8K: used_mask = 3'h4;
        `DENS_16K: used_mask = 3'h0;
        default: used_mask = 3'h7;
      endcase
    end
  endfunction

  line_filter u_scl
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .line_in  (scl_in),
    .line_out (scl_f)
  );

  line_filter u_sda
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .line_in  (sda_in),
    .line_out (sda_f)
  );

  busy_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_busy
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .start   (program_start),
    .busy    (busy_int)
  );

  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_c  = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_c   = scl_f & scl_d & ~sda_d & sda_f;
  wire [7:0] rx_next = {shift[6:0], sda_f};
  // floating pins are assumed pulled to zero outside, so a plain match
  wire addr_hit = (rx_next[7:4] == `TYPE_PATTERN)
    && (((rx_next[3:1] ^ pin_b) & used_mask(density)) == 3'h0);

  // select pin inputs pass two flops, write protect passes three
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_a   <= 3'h0;
      pin_b   <= 3'h0;
      wp_sync <= 3'h0;
    end
    else if (clk_en)
    begin
      pin_a   <= {select_pin_two, select_pin_one, select_pin_zero};
      pin_b   <= pin_a;
      wp_sync <= {wp_sync[1], wp_sync[0], write_protect};
    end
  end

  // main bus sequencer
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_d         <= 1'b1;
      sda_d         <= 1'b1;
      state         <= ST_IDLE;
      bit_cnt       <= {`BIT_CNT_W{1'b0}};
      shift         <= 8'h00;
      tx_shift      <= 8'h00;
      pend_ack      <= 1'b0;
      bytes_seen    <= 1'b0;
      wrote_data    <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      read_data_req <= 1'b0;
      selected      <= 1'b0;
      read_mode     <= 1'b0;
      high_address  <= 3'h0;
      rx_byte       <= 8'h00;
      rx_addr_valid <= 1'b0;
      rx_data_valid <= 1'b0;
      program_start <= 1'b0;
      busy          <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_d         <= scl_f;
      sda_d         <= sda_f;
      sda_out       <= 1'b0;  // only ever pulls low
      read_data_req <= 1'b0;
      rx_addr_valid <= 1'b0;
      rx_data_valid <= 1'b0;
      program_start <= 1'b0;
      busy          <= busy_int;
      if (stop_c)
      begin
        // programming begins only when a data byte was taken
        if (state == ST_WRITE && wrote_data)
          program_start <= 1'b1;
        state    <= ST_IDLE;
        sda_oe   <= 1'b0;
        selected <= 1'b0;
      end
      else if (start_c)
      begin
        // repeated start is accepted in any state
        state      <= ST_ADDR;
        // the clock fall that closes the start wraps this to bit zero
        bit_cnt    <= `BIT_PRE;
        sda_oe     <= 1'b0;
        selected   <= 1'b0;
        bytes_seen <= 1'b0;
        wrote_data <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_WRITE:
          begin
            if (scl_rise && bit_cnt <= `BIT_LAST)
              shift <= rx_next;
            if (scl_rise && bit_cnt == `BIT_LAST)
            begin
              rx_byte <= rx_next;
              if (state == ST_ADDR)
              begin
                // busy device stays silent on its address
                pend_ack <= addr_hit & ~busy_int;
                if (addr_hit && !busy_int)
                begin
                  selected      <= 1'b1;
                  read_mode     <= rx_next[0];
                  high_address  <= rx_next[3:1] & ~used_mask(density);
                  rx_addr_valid <= 1'b1;
                end
              end
              else if (!bytes_seen)
              begin
                pend_ack      <= 1'b1;
                bytes_seen    <= 1'b1;
                rx_data_valid <= 1'b1;
              end
              else
              begin
                // protected: refuse the first data byte, nothing programs
                pend_ack      <= ~wp_sync[2];
                wrote_data    <= ~wp_sync[2];
                rx_data_valid <= ~wp_sync[2];
              end
            end
            if (scl_fall)
            begin
              if (bit_cnt == `BIT_LAST)
              begin
                sda_oe  <= pend_ack;
                bit_cnt <= `BIT_ACK;
                if (!pend_ack)
                  state <= ST_WAIT;
              end
              else if (bit_cnt == `BIT_ACK)
              begin
                sda_oe  <= 1'b0;
                bit_cnt <= {`BIT_CNT_W{1'b0}};
                if (state == ST_ADDR)
                begin
                  if (read_mode)
                  begin
                    state         <= ST_READ;
                    sda_oe        <= ~read_data[7];
                    tx_shift      <= {read_data[6:0], 1'b0};
                    read_data_req <= 1'b1;
                  end
                  else
                    state <= ST_WRITE;
                end
              end
              else
                bit_cnt <= bit_cnt + 1'b1;
            end
          end
          ST_READ:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == `BIT_LAST)
              begin
                sda_oe  <= 1'b0;  // release for master ack
                bit_cnt <= `BIT_ACK;
              end
              else if (bit_cnt == `BIT_ACK)
              begin
                bit_cnt <= {`BIT_CNT_W{1'b0}};
                if (pend_ack)
                begin
                  sda_oe        <= ~read_data[7];
                  tx_shift      <= {read_data[6:0], 1'b0};
                  read_data_req <= 1'b1;
                end
                else
                  state <= ST_WAIT;
              end
              else
              begin
                sda_oe   <= ~tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
                bit_cnt  <= bit_cnt + 1'b1;
              end
            end
            // master ack sampled at the ninth clock rise
            if (scl_rise && bit_cnt == `BIT_ACK)
              pend_ack <= ~sda_f;
          end
          ST_WAIT:
            sda_oe <= 1'b0;
          default:
            sda_oe <= 1'b0;  // idle ignores the bus
        endcase
      end
    end
  end
endmodule // eeprom_serial_slave_interface

// ### verification/eeprom_slave_checker_assertions.sv
// concurrent checks on the eeprom slave front end ports
`timescale 1ns/1ns
module eeprom_slave_checker
(
  input wire       clk_sys,
  input wire       rst_n,
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       write_protect,
  input wire       read_data_req,
  input wire       selected,
  input wire       read_mode,
  input wire [7:0] rx_byte,
  input wire       rx_addr_valid,
  input wire       rx_data_valid,
  input wire       program_start,
  input wire       busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // protect must outlast the three-flop synchroniser
  sequence wp_held;
    write_protect [*5];
  endsequence
  // address byte settled two cycles after its strobe
  sequence addr_taken;
    rx_addr_valid ##2 1'b1;
  endsequence
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  AST_DATA_CLOCK_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved with clock high");
  AST_WP_NO_PROG: assert property (wp_held |-> !program_start)
    else $error("programming while protected");
  AST_BUSY_QUIET: assert property (busy |-> !sda_oe)
    else $error("data driven while busy");
  AST_PROG_BUSY: assert property (program_start |-> ##[0:3] busy)
    else $error("no busy after program start");
  AST_ADDR_TYPE: assert property (addr_taken |-> rx_byte[7:4] == 4'ha)
    else $error("address accepted with bad type");
  AST_ADDR_DIR: assert property (addr_taken |-> selected && read_mode == rx_byte[0])
    else $error("direction or select wrong");
  AST_REQ_READ: assert property (read_data_req |-> read_mode && selected)
    else $error("byte fetch outside a read");
  AST_RX_WRITE: assert property (rx_data_valid |-> selected && !read_mode)
    else $error("byte taken outside a write");
endmodule // eeprom_slave_checker

// ### verification/bus_master_model.sv
// behavioural two-wire bus master driving the serial clock
`timescale 1ns/1ns
module bus_master_model
(
  input  wire clk_sys,
  input  wire sda,
  output reg  scl,
  output reg  sda_m
);
  // clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task cyc(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  // 6 low, 2 high: slave answers well inside the low phase
  task bit_io(input b, output r);
  begin
    cyc(2);
    sda_m = b;
    cyc(4);
    scl = 1'b1;
    cyc(1);
    r = sda;
    cyc(1);
    scl = 1'b0;
  end
  endtask
  task start;
  begin
    sda_m = 1'b1;
    cyc(2);
    scl = 1'b1;
    cyc(4);
    sda_m = 1'b0;
    cyc(4);
    scl = 1'b0;
  end
  endtask
  task stop;
  begin
    cyc(2);
    sda_m = 1'b0;
    cyc(4);
    scl = 1'b1;
    cyc(4);
    sda_m = 1'b1;
    cyc(8);
  end
  endtask
  task wbyte(input [7:0] b, output nak);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(b[i], r);
    bit_io(1'b1, nak);
  end
  endtask
  task rbyte(input ack_n, output [7:0] b);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(1'b1, b[i]);
    bit_io(ack_n, r);
  end
  endtask
endmodule // bus_master_model

// ### verification/eeprom_serial_slave_interface_tb.sv
// self-checking bench for the two-wire eeprom slave front end
`timescale 1ns/1ns
module eeprom_serial_slave_interface_tb;
  reg        clk_sys = 1'b0;
  reg        rst_n = 1'b0;
  reg  [2:0] density = 3'h3;
  reg  [2:0] pins = 3'h4;
  reg        write_protect = 1'b0;
  reg        clk_en = 1'b1;
  reg  [7:0] rd_cnt = 8'h00;
  reg  [7:0] b;
  reg        nak;
  wire       scl, sda_m, sda, sda_out, sda_oe, read_data_req, selected, read_mode;
  wire       rx_addr_valid, rx_data_valid, program_start, busy;
  wire [2:0] high_address;
  wire [7:0] rx_byte;
  wire [7:0] read_data;
  integer    num_errors = 0;
  integer    n_tests = 0;
  integer    cyc_cnt = 0;
  integer    n_prog = 0;
  integer    d;
  always #50 clk_sys = ~clk_sys;
  // pull-up on the data wire, both parties only pull low
  assign sda = sda_m & ~sda_oe;
  assign read_data = 8'hc3 ^ rd_cnt;
  eeprom_serial_slave_interface #(.WRITE_CYCLES(200)) eeprom_serial_slave_interface_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .density(density), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_zero(pins[0]),
    .select_pin_one(pins[1]), .select_pin_two(pins[2]), .write_protect(write_protect),
    .read_data(read_data), .read_data_req(read_data_req), .selected(selected),
    .read_mode(read_mode), .high_address(high_address), .rx_byte(rx_byte),
    .rx_addr_valid(rx_addr_valid), .rx_data_valid(rx_data_valid),
    .program_start(program_start), .busy(busy));
  bus_master_model bus_master_model_inst (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .sda_m(sda_m));
  // fetch counter, program counter and hang guard
  always @(posedge clk_sys)
  begin
    cyc_cnt = cyc_cnt + 1;
    if (read_data_req === 1'b1)
      rd_cnt <= rd_cnt + 8'h01;
    if (program_start === 1'b1)
      n_prog = n_prog + 1;
    if (cyc_cnt == 20000)
    begin
      num_errors = num_errors + 1;
      close_out;
    end
  end
  task close_out;
  begin
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      num_errors = num_errors + 1;
    end
  end
  endtask
  task addr(input [7:0] a, input exp_nak);
  begin
    bus_master_model_inst.start;
    bus_master_model_inst.wbyte(a, nak);
    chk({7'h00, nak}, {7'h00, exp_nak});
  end
  endtask
  task wr(input [7:0] v, input exp_nak);
  begin
    bus_master_model_inst.wbyte(v, nak);
    chk({7'h00, nak}, {7'h00, exp_nak});
  end
  endtask
  task rd(input ack_n, input [7:0] exp);
  begin
    bus_master_model_inst.rbyte(ack_n, b);
    chk(b, exp);
  end
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    addr(8'hac, 1'b0);
    chk({5'h00, high_address}, 8'h02);
    wr(8'h12, 1'b0);
    wr(8'h5e, 1'b0);
    chk(rx_byte, 8'h5e);
    bus_master_model_inst.stop;
    chk(n_prog, 8'h01);
    chk({7'h00, busy}, 8'h01);
    // freeze longer than the write cycle: busy must still stand after it
    clk_en = 1'b0;
    repeat (300) @(negedge clk_sys);
    clk_en = 1'b1;
    chk({7'h00, busy}, 8'h01);
    addr(8'hac, 1'b1);
    bus_master_model_inst.stop;
    repeat (200) if (busy !== 1'b0) @(negedge clk_sys);
    addr(8'hbc, 1'b1);
    bus_master_model_inst.stop;
    addr(8'ha2, 1'b1);
    bus_master_model_inst.stop;
    write_protect = 1'b1;
    addr(8'hac, 1'b0);
    wr(8'h34, 1'b0);
    wr(8'h56, 1'b1);
    bus_master_model_inst.stop;
    chk(n_prog, 8'h01);
    write_protect = 1'b0;
    addr(8'had, 1'b0);
    chk({7'h00, read_mode}, 8'h01);
    rd(1'b0, 8'hc3);
    rd(1'b1, 8'hc2);
    bus_master_model_inst.stop;
    chk(rd_cnt, 8'h02);
    pins = 3'h7;
    for (d = 0; d < 5; d = d + 1)
    begin
      density = d[2:0];
      addr(8'ha0, d != 4);
      bus_master_model_inst.stop;
      addr(8'hac, d < 2);
      bus_master_model_inst.stop;
    end
    close_out;
  end
endmodule // eeprom_serial_slave_interface_tb
bind eeprom_serial_slave_interface eeprom_slave_checker eeprom_slave_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect(write_protect), .read_data_req(read_data_req), .selected(selected),
  .read_mode(read_mode), .rx_byte(rx_byte), .rx_addr_valid(rx_addr_valid),
  .rx_data_valid(rx_data_valid), .program_start(program_start), .busy(busy));
